// [rtl/hsp_pkg.sv]
// Shared constants for the host service parallel port ends
package hsp_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 25;

  // Device register offsets on the 7-bit host address
  localparam logic [6:0] ADDR_SVC_EN = 7'h06;
  localparam logic [6:0] ADDR_FW_REV = 7'h40;
  localparam logic [6:0] ADDR_MDM_VEC = 7'h41;
  localparam logic [6:0] ADDR_TX_VEC = 7'h42;
  localparam logic [6:0] ADDR_RX_VEC = 7'h43;
  localparam logic [6:0] ADDR_MODE = 7'h4B;
  localparam logic [6:0] ADDR_RX_DATA = 7'h62;
  localparam logic [6:0] ADDR_TX_DATA = 7'h63;
  localparam logic [6:0] ADDR_PRN_SIG = 7'h6F;

  // Mode register bit positions
  localparam int MODE_TX_EN = 0;
  localparam int MODE_RX_EN = 1;
  localparam int MODE_PAR = 2;
  localparam int MODE_PAR_IN = 3;
  localparam int MODE_CTS_FLOW = 4;

  // Service enable and service type index (rx, tx, modem)
  localparam int SVC_RX = 0;
  localparam int SVC_TX = 1;
  localparam int SVC_MDM = 2;

  // Interrupt vector values presented in service acknowledge cycles
  localparam logic [7:0] VEC_RX = 8'h03;
  localparam logic [7:0] VEC_TX = 8'h02;
  localparam logic [7:0] VEC_MDM = 8'h01;

  // Printer signal register: outputs in [2:0], status inputs in [7:4]
  localparam int PSIG_SEL_IN = 0;
  localparam int PSIG_INIT = 1;
  localparam int PSIG_AUTOFEED = 2;
  localparam int PSIG_STAT_LSB = 4;

  // Parallel handshake times and their cycle counts (least times, rounded up)
  localparam int SETUP_NS = 500;
  localparam int STROBE_NS = 1000;
  localparam int HOLD_NS = 500;
  localparam int ACK_OUT_NS = 1000;
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACK_OUT_CYC = 8'((ACK_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Device reset hold driven by the host, in system clocks
  localparam logic [3:0] RESET_HOLD_CYC = 4'hA;

  // Host software port offsets and command kinds
  localparam logic [2:0] SW_ADDR = 3'h0;
  localparam logic [2:0] SW_WDATA = 3'h1;
  localparam logic [2:0] SW_GO = 3'h2;
  localparam logic [2:0] SW_STAT = 3'h3;
  localparam logic [2:0] SW_RDATA = 3'h4;
  localparam logic [1:0] KIND_PLAIN = 2'h0;
  localparam logic [1:0] KIND_RX = 2'h1;
  localparam logic [1:0] KIND_TX = 2'h2;
  localparam logic [1:0] KIND_MDM = 2'h3;
  localparam int GO_READ = 2;
endpackage

// [rtl/hsp_link_if.sv]
// Host bus, service request lines and daisy chain between host and device
interface hsp_link_if;
  // Host driven
  logic rst_n;
  logic cs_n;
  logic data_strobe_n;
  logic rw;
  logic [6:0] addr;
  logic [7:0] host_dout;
  logic host_doe;
  logic [2:0] svc_ack_n;
  logic chain_grant_in_n;
  // Device driven
  logic [7:0] dev_dout;
  logic dev_doe;
  logic ack_oe;
  logic [2:0] req_oe;
  logic chain_pass_out_n;
  // Resolved wires; open-drain lines float high through pull-ups
  logic [7:0] db;
  logic transfer_ack_n;
  logic [2:0] svc_req_n;

  assign db = host_doe ? host_dout : (dev_doe ? dev_dout : 8'hFF);
  assign transfer_ack_n = ~ack_oe;
  assign svc_req_n = ~req_oe;

  modport device (
    input rst_n, cs_n, data_strobe_n, rw, addr, db, svc_ack_n, chain_grant_in_n,
    output dev_dout, dev_doe, ack_oe, req_oe, chain_pass_out_n
  );
  modport host (
    input db, transfer_ack_n, svc_req_n, chain_pass_out_n,
    output rst_n, cs_n, data_strobe_n, rw, addr, host_dout, host_doe, svc_ack_n, chain_grant_in_n
  );
endinterface

// [rtl/hsp_device.sv]
// Device end: host register port, service requests, daisy chain, channel 0 parallel port
// Notes on behaviour
// - Host holds reset low ten clocks
// - After reset: clear, disable, load revision
// - Host bus timing runs at half system clock
// - Respond only to chip select with strobe
// - Write captures, read drives data bus
// - Direction high read, low write, held
// - Acknowledge once done; host may end
// - Seven-bit address, eight-bit data bus
// - Separate rx, tx, modem service requests
// - Service acknowledge reads that type's vector
// - Service cycle needs grant, strobe, acknowledge
// - Pass chain when no matching request
// - Parallel mode reassigns channel 0, data pins
// - Data set up before, held after strobe
// - Next output byte waits for printer acknowledge
// - Input mode swaps strobe and acknowledge roles
// - Input: busy, release after taking, acknowledge
// - Busy output on receive, input on transmit
// - Select low latches, high passes through
// - Three printer outputs follow signal register
// - Printer status readable, change raises modem
// - CTS flow gates each transmitter
module hsp_device
  import hsp_pkg::*;
#(
  parameter logic [7:0] FW_REVISION = 8'h5A  // Arbitrary revision value
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Host side
  hsp_link_if.device lk,
  // Serial channel pins (channel 0 cts doubles as printer selected)
  input wire logic i_ser_txd0,
  input wire logic [3:0] i_cts_n,
  output logic o_txd0,
  output logic [3:0] o_tx_allow,
  // Parallel printer pins
  input wire logic i_printer_ack_n,
  input wire logic i_paper_empty_n,
  input wire logic i_printer_fault_n,
  input wire logic i_printer_busy,
  output logic o_printer_busy,
  output logic o_printer_busy_oe,
  output logic o_printer_select_in_n,
  output logic o_printer_init_n,
  output logic o_printer_autofeed_n,
  // Parallel data bits; bits 2..7 share the carrier-detect and ring pins of channels 1..3
  input wire logic [7:0] i_parallel_data_bit,
  output logic [7:0] o_parallel_data_bit,
  output logic [7:0] o_parallel_data_bit_oe
);
  typedef enum logic [1:0] {B_IDLE = 2'b00, B_WORK = 2'b01, B_ACK = 2'b10, B_PASS = 2'b11} bus_st_t;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_SETUP = 3'b001, P_STRB = 3'b010, P_HOLD = 3'b011,
    P_WACK = 3'b100, P_RBUSY = 3'b101, P_RACK = 3'b110
  } par_st_t;
  typedef struct packed {
    logic init;
    logic half;
    logic [7:0] fw_rev;
    logic [7:0] mode;
    logic [2:0] svc_en;
    logic [2:0] prn_sig;
    logic [7:0] tx_data;
    logic tx_full;
    logic [7:0] rx_data;
    logic rx_full;
    logic mdm_chg;
    logic [3:0] stat_prev;
    logic ack_in_prev;
    bus_st_t bst;
    logic [1:0] svc_type;
    logic [7:0] dout;
    logic doe;
    logic ack_oe;
    logic [2:0] req_oe;
    logic pass_n;
    par_st_t pst;
    logic [7:0] cnt;
    logic strobe_n;
    logic [7:0] par_dout;
    logic par_doe;
    logic busy_out;
    logic busy_oe;
    logic txd0;
    logic [3:0] tx_allow;
  } dev_st_t;

  dev_st_t s, n;

  function automatic dev_st_t rst_val();
    dev_st_t r;
    r = '0;
    r.init = 1'b1;
    r.pass_n = 1'b1;
    r.strobe_n = 1'b1;
    r.txd0 = 1'b1;
    r.ack_in_prev = 1'b1;
    r.stat_prev = 4'hF;
    return r;
  endfunction

  function automatic logic [7:0] rd_mux(input dev_st_t st, input logic [6:0] a, input logic [3:0] stat);
    unique case (a)
      ADDR_FW_REV: rd_mux = st.fw_rev;
      ADDR_MODE: rd_mux = st.mode;
      ADDR_SVC_EN: rd_mux = {5'h00, st.svc_en};
      ADDR_RX_DATA: rd_mux = st.rx_data;
      ADDR_RX_VEC: rd_mux = VEC_RX;
      ADDR_TX_VEC: rd_mux = VEC_TX;
      ADDR_MDM_VEC: rd_mux = VEC_MDM;
      ADDR_PRN_SIG: rd_mux = {stat, 1'b0, st.prn_sig};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  logic par_mode, par_out_on, par_in_on, ack_fall, svc_cycle, host_cycle;
  logic [3:0] pstat;
  logic [2:0] reqs;
  logic [1:0] ack_type;

  always_comb begin
    par_mode = s.mode[MODE_PAR];
    par_out_on = par_mode & ~s.mode[MODE_PAR_IN] & s.mode[MODE_TX_EN];
    par_in_on = par_mode & s.mode[MODE_PAR_IN] & s.mode[MODE_RX_EN];
    ack_fall = s.ack_in_prev & ~i_printer_ack_n;
    // Busy pin is only an input on transmit, reported but never gating
    pstat = {i_printer_fault_n, i_paper_empty_n, i_cts_n[0], i_printer_busy};
    reqs[SVC_RX] = s.svc_en[SVC_RX] & s.rx_full;
    reqs[SVC_TX] = s.svc_en[SVC_TX] & par_out_on & ~s.tx_full;
    reqs[SVC_MDM] = s.svc_en[SVC_MDM] & s.mdm_chg;
    host_cycle = ~lk.cs_n & ~lk.data_strobe_n;
    svc_cycle = ~lk.data_strobe_n & ~lk.chain_grant_in_n & (lk.svc_ack_n != 3'b111);
    if (!lk.svc_ack_n[SVC_RX]) begin
      ack_type = 2'(SVC_RX);
    end else if (!lk.svc_ack_n[SVC_TX]) begin
      ack_type = 2'(SVC_TX);
    end else begin
      ack_type = 2'(SVC_MDM);
    end

    n = s;
    n.half = ~s.half;
    n.ack_in_prev = i_printer_ack_n;
    n.req_oe = s.init ? 3'b000 : reqs;
    n.txd0 = par_mode ? s.strobe_n : i_ser_txd0;
    for (int i = 0; i < 4; i++) begin
      n.tx_allow[i] = s.mode[MODE_TX_EN] & ~(i == 0 & par_mode) & (~s.mode[MODE_CTS_FLOW] | ~i_cts_n[i]);
    end
    n.busy_oe = par_in_on;

    // Status change detection for the modem service request
    n.stat_prev = pstat;
    if (par_mode && pstat != s.stat_prev) begin
      n.mdm_chg = 1'b1;
    end

    // Host bus, stepped on the divided clock
    if (s.half) begin
      unique case (s.bst)
        B_IDLE: begin
          if (!s.init && host_cycle) begin
            n.bst = B_WORK;
          end else if (!s.init && svc_cycle) begin
            n.svc_type = ack_type;
            if (reqs[ack_type]) begin
              n.bst = B_WORK;
            end else begin
              n.pass_n = 1'b0;
              n.bst = B_PASS;
            end
          end
        end
        B_WORK: begin
          if (lk.cs_n) begin
            // Vector read of a service acknowledge cycle
            n.dout = rd_mux(s, 7'(ADDR_MDM_VEC + 7'(2'(SVC_MDM) - s.svc_type)), pstat);
            n.doe = 1'b1;
            if (s.svc_type == 2'(SVC_MDM)) begin
              n.mdm_chg = 1'b0;
            end
          end else if (lk.rw) begin
            n.dout = rd_mux(s, lk.addr, pstat);
            n.doe = 1'b1;
            if (lk.addr == ADDR_RX_DATA) begin
              n.rx_full = 1'b0;
            end
          end else begin
            unique case (lk.addr)
              ADDR_MODE: n.mode = lk.db;
              ADDR_SVC_EN: n.svc_en = lk.db[2:0];
              ADDR_PRN_SIG: n.prn_sig = lk.db[2:0];
              ADDR_FW_REV: n.fw_rev = lk.db;
              ADDR_TX_DATA: begin
                if (!s.tx_full) begin
                  n.tx_data = lk.db;
                  n.tx_full = 1'b1;
                end
              end
              default: ;
            endcase
          end
          n.ack_oe = 1'b1;
          n.bst = B_ACK;
        end
        B_ACK: begin
          if (lk.data_strobe_n) begin
            n.ack_oe = 1'b0;
            n.doe = 1'b0;
            n.bst = B_IDLE;
          end
        end
        B_PASS: begin
          if (lk.data_strobe_n || lk.svc_ack_n == 3'b111) begin
            n.pass_n = 1'b1;
            n.bst = B_IDLE;
          end
        end
      endcase
    end

    // A status change in the clearing cycle still sets the flag
    if (par_mode && pstat != s.stat_prev) begin
      n.mdm_chg = 1'b1;
    end

    // Channel 0 parallel handshake
    if (par_in_on && i_cts_n[0]) begin
      n.rx_data = i_parallel_data_bit;
    end
    n.cnt = (s.cnt != 8'h00) ? s.cnt - 8'h01 : 8'h00;
    unique case (s.pst)
      P_IDLE: begin
        if (par_out_on && s.tx_full) begin
          n.par_dout = s.tx_data;
          n.par_doe = 1'b1;
          n.cnt = SETUP_CYC - 8'h01;
          n.pst = P_SETUP;
        end else if (par_in_on && ack_fall && !s.rx_full) begin
          n.busy_out = 1'b1;
          if (!i_cts_n[0]) begin
            n.rx_data = i_parallel_data_bit;
          end
          n.pst = P_RBUSY;
        end
      end
      P_SETUP: begin
        if (s.cnt == 8'h00) begin
          n.strobe_n = 1'b0;
          n.cnt = STROBE_CYC - 8'h01;
          n.pst = P_STRB;
        end
      end
      P_STRB: begin
        if (s.cnt == 8'h00) begin
          n.strobe_n = 1'b1;
          n.cnt = HOLD_CYC - 8'h01;
          n.pst = P_HOLD;
        end
      end
      P_HOLD: begin
        if (s.cnt == 8'h00) begin
          n.par_doe = 1'b0;
          n.pst = P_WACK;
        end
      end
      P_WACK: begin
        if (!i_printer_ack_n) begin
          n.tx_full = 1'b0;
          n.pst = P_IDLE;
        end
      end
      P_RBUSY: begin
        n.rx_full = 1'b1;
        n.busy_out = 1'b0;
        n.strobe_n = 1'b0;
        n.cnt = ACK_OUT_CYC - 8'h01;
        n.pst = P_RACK;
      end
      P_RACK: begin
        if (s.cnt == 8'h00) begin
          n.strobe_n = 1'b1;
          n.pst = P_IDLE;
        end
      end
      default: n.pst = P_IDLE;
    endcase

    // Leaving parallel mode abandons any handshake in flight
    if (!par_mode) begin
      n.pst = P_IDLE;
      n.strobe_n = 1'b1;
      n.par_doe = 1'b0;
      n.busy_out = 1'b0;
    end

    // One cycle after release: transmitters and receivers off, revision loaded
    if (s.init) begin
      n.mode = 8'h00;
      n.fw_rev = FW_REVISION;
      n.init = 1'b0;
    end
    if (!lk.rst_n) begin
      n = rst_val();
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= rst_val();
    end else begin
      s <= n;
    end
  end

  assign lk.dev_dout = s.dout;
  assign lk.dev_doe = s.doe;
  assign lk.ack_oe = s.ack_oe;
  assign lk.req_oe = s.req_oe;
  assign lk.chain_pass_out_n = s.pass_n;
  assign o_txd0 = s.txd0;
  assign o_tx_allow = s.tx_allow;
  assign o_printer_busy = s.busy_out;
  assign o_printer_busy_oe = s.busy_oe;
  assign o_printer_select_in_n = s.prn_sig[PSIG_SEL_IN];
  assign o_printer_init_n = s.prn_sig[PSIG_INIT];
  assign o_printer_autofeed_n = s.prn_sig[PSIG_AUTOFEED];
  assign o_parallel_data_bit = s.par_dout;
  assign o_parallel_data_bit_oe = {8{s.par_doe}};
endmodule

// [rtl/hsp_host.sv]
// Host end: runs device bus and service acknowledge cycles on software command
module hsp_host
  import hsp_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Software port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Device side
  hsp_link_if.host lk
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SETUP = 2'b01, H_STRB = 2'b10, H_END = 2'b11} host_st_t;
  typedef struct packed {
    host_st_t st;
    logic [3:0] rst_cnt;
    logic rst_n;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [1:0] kind;
    logic rd;
    logic busy;
    logic no_taker;
    logic [7:0] result;
    logic [7:0] rdata;
    logic cs_n;
    logic strobe_n;
    logic rw;
    logic doe;
    logic [2:0] sack_n;
    logic grant_n;
  } host_state_t;

  host_state_t s, n;

  always_comb begin
    n = s;
    n.rdata = 8'h00;
    // Device reset held low for the required count after our own reset
    if (s.rst_cnt != RESET_HOLD_CYC) begin
      n.rst_cnt = s.rst_cnt + 4'h1;
    end else begin
      n.rst_n = 1'b1;
    end
    if (i_rd) begin
      unique case (i_addr)
        SW_ADDR: n.rdata = {1'b0, s.addr};
        SW_WDATA: n.rdata = s.wdata;
        SW_STAT: n.rdata = {3'b000, ~lk.svc_req_n, s.no_taker, s.busy};
        SW_RDATA: n.rdata = s.result;
        default: n.rdata = 8'h00;
      endcase
    end
    if (i_wr && !s.busy) begin
      unique case (i_addr)
        SW_ADDR: n.addr = i_wdata[6:0];
        SW_WDATA: n.wdata = i_wdata;
        SW_GO: begin
          if (s.rst_n) begin
            n.kind = i_wdata[1:0];
            n.rd = i_wdata[GO_READ] | (i_wdata[1:0] != KIND_PLAIN);
            n.busy = 1'b1;
            n.no_taker = 1'b0;
            n.st = H_SETUP;
          end
        end
        default: ;
      endcase
    end
    unique case (s.st)
      H_IDLE: ;
      H_SETUP: begin
        // Direction and address stay put for the whole access
        n.rw = s.rd;
        if (s.kind == KIND_PLAIN) begin
          n.cs_n = 1'b0;
          n.doe = ~s.rd;
        end else begin
          n.sack_n = ~(3'b001 << (s.kind - 2'h1));
          n.grant_n = 1'b0;
        end
        n.st = H_STRB;
      end
      H_STRB: begin
        n.strobe_n = 1'b0;
        if (!s.strobe_n && (!lk.transfer_ack_n || (s.kind != KIND_PLAIN && !lk.chain_pass_out_n))) begin
          if (!lk.transfer_ack_n) begin
            if (s.rd) begin
              n.result = lk.db;
            end
          end else begin
            n.no_taker = 1'b1;
          end
          n.strobe_n = 1'b1;
          n.cs_n = 1'b1;
          n.doe = 1'b0;
          n.sack_n = 3'b111;
          n.grant_n = 1'b1;
          n.st = H_END;
        end
      end
      H_END: begin
        if (lk.transfer_ack_n && lk.chain_pass_out_n) begin
          n.busy = 1'b0;
          n.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
      s.cs_n <= 1'b1;
      s.strobe_n <= 1'b1;
      s.rw <= 1'b1;
      s.sack_n <= 3'b111;
      s.grant_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign lk.rst_n = s.rst_n;
  assign lk.cs_n = s.cs_n;
  assign lk.data_strobe_n = s.strobe_n;
  assign lk.rw = s.rw;
  assign lk.addr = s.addr;
  assign lk.host_dout = s.wdata;
  assign lk.host_doe = s.doe;
  assign lk.svc_ack_n = s.sack_n;
  assign lk.chain_grant_in_n = s.grant_n;
endmodule

// [testbench/hsp_link_chk.sv]
// Concurrent checks on the host link between the host and device ends
module hsp_link_chk
  import hsp_pkg::*;
(
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic rst_n,
  // Host driven
  input wire logic cs_n,
  input wire logic data_strobe_n,
  input wire logic rw,
  input wire logic [2:0] svc_ack_n,
  input wire logic chain_grant_in_n,
  // Device driven
  input wire logic [7:0] dev_dout,
  input wire logic dev_doe,
  input wire logic ack_oe,
  input wire logic [2:0] req_oe,
  input wire logic chain_pass_out_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] low_cnt_q;
  logic svc_any;

  assign svc_any = (svc_ack_n != 3'h7);

  // Saturates so a long host reset cannot wrap and look short
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_cnt_q <= 8'h00;
    end else if (rst_n) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n || !rst_n);

  sequence plain_start;
    !cs_n && $fell(data_strobe_n);
  endsequence
  sequence ack_in_time;
    ##[2:4] ack_oe;
  endsequence
  sequence strobe_release;
    $rose(data_strobe_n);
  endsequence

  chk_reset_hold: assert property (disable iff (!i_arst_n) $rose(rst_n) |-> low_cnt_q >= 8'h0A)
    else $error("device reset released too early");
  chk_ack_cause: assert property ($rose(ack_oe) |-> !data_strobe_n && (!cs_n || svc_any))
    else $error("acknowledge without select and strobe");
  chk_ack_latency: assert property (plain_start |-> ack_in_time)
    else $error("acknowledge late");
  chk_ack_release: assert property (strobe_release |-> ##[1:2] (!ack_oe && !dev_doe))
    else $error("acknowledge or data held after strobe");
  chk_read_drive: assert property (ack_oe && rw && !cs_n |-> dev_doe)
    else $error("read acknowledged without data drive");
  chk_write_quiet: assert property (!cs_n && !rw |-> !dev_doe)
    else $error("device drives bus in write");
  chk_grant_needed: assert property ($rose(ack_oe) && cs_n |-> !chain_grant_in_n && svc_any)
    else $error("service cycle without grant");
  chk_vec_rx: assert property (ack_oe && dev_doe && cs_n && !svc_ack_n[SVC_RX] |-> dev_dout == VEC_RX)
    else $error("wrong receive vector");
  chk_vec_modem: assert property (ack_oe && dev_doe && cs_n && (svc_ack_n == 3'h3) |-> dev_dout == VEC_MDM)
    else $error("wrong modem vector");
  chk_pass_no_req: assert property ($fell(chain_pass_out_n) |-> svc_any && !ack_oe)
    else $error("chain passed outside service cycle");
  chk_pass_rx_idle: assert property (!chain_pass_out_n && !svc_ack_n[SVC_RX] |-> !req_oe[SVC_RX])
    else $error("chain passed with receive request");
endmodule

// [testbench/host_service_parallel_port_tb.sv]
// Self-checking bench joining host and device ends over the host link
module host_service_parallel_port_tb
  import hsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] FW_REV_VAL = 8'h5A;  // Arbitrary revision value
  localparam logic [2:0] RD = {1'b1, KIND_PLAIN};
  localparam logic [2:0] WR = {1'b0, KIND_PLAIN};
  localparam logic [7:0] M_TX = 8'(1 << MODE_TX_EN);
  localparam logic [7:0] M_RX = 8'(1 << MODE_RX_EN);
  localparam logic [7:0] M_PAR = 8'(1 << MODE_PAR);
  localparam logic [7:0] M_IN = 8'(1 << MODE_PAR_IN);
  localparam logic [7:0] M_CTS = 8'(1 << MODE_CTS_FLOW);

  logic clk, arst_n, sw_wr_s, sw_rd_s, ser_txd0, far_ack_n, pe_n, fault_n, busy_in, sawb;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, far_data, dev_data, dev_data_oe, rdv, stat;
  logic [3:0] cts_n, tx_allow;
  logic txd0, dev_busy, dev_busy_oe, sel_in_n, init_n, autofeed_n;
  logic [7:0] data_wire;
  logic busy_wire;
  int err_total, cmp_count;

  // Far-side pins resolve between the device drive and the remote printer
  assign data_wire = (dev_data_oe & dev_data) | (~dev_data_oe & far_data);
  assign busy_wire = dev_busy_oe ? dev_busy : busy_in;

  hsp_link_if lk_if();
  hsp_host i_hsp_host (.i_sys_clk(clk), .i_arst_n(arst_n), .i_addr(sw_addr), .i_wdata(sw_wdata),
    .i_wr(sw_wr_s), .i_rd(sw_rd_s), .o_rdata(sw_rdata), .lk(lk_if));
  hsp_device #(.FW_REVISION(FW_REV_VAL)) i_hsp_device (.i_sys_clk(clk), .i_arst_n(arst_n), .lk(lk_if),
    .i_ser_txd0(ser_txd0), .i_cts_n(cts_n), .o_txd0(txd0), .o_tx_allow(tx_allow),
    .i_printer_ack_n(far_ack_n), .i_paper_empty_n(pe_n), .i_printer_fault_n(fault_n),
    .i_printer_busy(busy_wire), .o_printer_busy(dev_busy), .o_printer_busy_oe(dev_busy_oe),
    .o_printer_select_in_n(sel_in_n), .o_printer_init_n(init_n), .o_printer_autofeed_n(autofeed_n),
    .i_parallel_data_bit(data_wire), .o_parallel_data_bit(dev_data), .o_parallel_data_bit_oe(dev_data_oe));
  hsp_link_chk i_hsp_link_chk (.i_sys_clk(clk), .i_arst_n(arst_n), .rst_n(lk_if.rst_n), .cs_n(lk_if.cs_n),
    .data_strobe_n(lk_if.data_strobe_n), .rw(lk_if.rw), .svc_ack_n(lk_if.svc_ack_n),
    .chain_grant_in_n(lk_if.chain_grant_in_n), .dev_dout(lk_if.dev_dout), .dev_doe(lk_if.dev_doe),
    .ack_oe(lk_if.ack_oe), .req_oe(lk_if.req_oe), .chain_pass_out_n(lk_if.chain_pass_out_n));

  always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr_s <= 1'b1;
    @(posedge clk);
    sw_wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd_s <= 1'b1;
    @(posedge clk);
    sw_rd_s <= 1'b0;
    // Taken at the closing edge, before that edge replaces the value
    @(posedge clk);
    d = sw_rdata;
  endtask

  // One device cycle: address, data, go, poll busy, fetch result
  task automatic op(input logic [2:0] go, input logic [6:0] a, input logic [7:0] wd);
    int n;
    sw_wr(SW_ADDR, {1'b0, a});
    sw_wr(SW_WDATA, wd);
    sw_wr(SW_GO, {5'h00, go});
    n = 0;
    do begin
      sw_rd(SW_STAT, stat);
      n++;
    end while (stat[0] !== 1'b0 && n < 50);
    check("op_done", 8'h00, {7'h00, stat[0]});
    sw_rd(SW_RDATA, rdv);
  endtask

  task automatic wait_txd(input logic lvl);
    for (int n = 0; n < 200 && txd0 !== lvl; n++) @(posedge clk);
    check("txd0_level", {7'h00, lvl}, {7'h00, txd0});
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {sw_wr_s, sw_rd_s, busy_in} = 3'h0;
    {ser_txd0, far_ack_n, pe_n, fault_n} = 4'hF;
    sw_addr = 3'h0;
    sw_wdata = 8'h00;
    far_data = 8'h00;
    cts_n = 4'hF;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    op(RD, ADDR_FW_REV, 8'h00); check("fw_rev", FW_REV_VAL, rdv);
    op(RD, ADDR_MODE, 8'h00); check("mode_reset", 8'h00, rdv);
    check("tx_allow_reset", 8'h00, {4'h0, tx_allow});
    op(RD, 7'h7F, 8'h00); check("unmapped", 8'h00, rdv);
    op(WR, ADDR_SVC_EN, 8'h07);
    op(RD, ADDR_SVC_EN, 8'h00); check("svc_enable", 8'h07, rdv);
    pe_n <= 1'b0;
    busy_in <= 1'b1;
    op(WR, ADDR_PRN_SIG, 8'h05);
    op(RD, ADDR_PRN_SIG, 8'h00); check("prn_sig", 8'hB5, rdv);
    check("prn_out", 8'h05, {5'h00, autofeed_n, init_n, sel_in_n});
    ser_txd0 <= 1'b0;
    cts_n <= 4'b0101;
    op(WR, ADDR_MODE, M_TX | M_CTS); check("cts_gate", 8'h0A, {4'h0, tx_allow});
    check("txd0_serial", 8'h00, {7'h00, txd0});
    op(WR, ADDR_MODE, M_TX); check("cts_free", 8'h0F, {4'h0, tx_allow});
    // Parallel output with the printer busy line high, which must not stall it
    ser_txd0 <= 1'b1;
    op(WR, ADDR_MODE, M_TX | M_PAR); check("req_tx", 8'h01, {7'h00, stat[2 + SVC_TX]});
    check("tx_allow_par", 8'h00, {7'h00, tx_allow[0]});
    check("busy_dir_tx", 8'h00, {7'h00, dev_busy_oe});
    op({1'b1, KIND_TX}, 7'h00, 8'h00); check("vec_tx", VEC_TX, rdv);
    op(WR, ADDR_TX_DATA, 8'hA5);
    wait_txd(1'b0);
    check("par_setup", 8'hA5, dev_data);
    check("par_drive", 8'hFF, dev_data_oe);
    wait_txd(1'b1);
    repeat (10) @(posedge clk);
    check("par_hold", 8'hA5, dev_data);
    check("par_hold_drive", 8'hFF, dev_data_oe);
    repeat (40) @(posedge clk);
    check("par_drive_off", 8'h00, dev_data_oe);
    op(RD, ADDR_MODE, 8'h00); check("wait_prn_ack", 8'h00, {7'h00, stat[2 + SVC_TX]});
    far_ack_n <= 1'b0;
    repeat (4) @(posedge clk);
    far_ack_n <= 1'b1;
    op(RD, ADDR_MODE, 8'h00); check("after_prn_ack", 8'h01, {7'h00, stat[2 + SVC_TX]});
    op({1'b1, KIND_RX}, 7'h00, 8'h00); check("no_taker", 8'h01, {7'h00, stat[1]});
    // Parallel input, latching on the remote strobe
    cts_n <= 4'b0100;
    far_data <= 8'h3C;
    op(WR, ADDR_MODE, M_RX | M_PAR | M_IN); check("busy_dir_rx", 8'h01, {7'h00, dev_busy_oe});
    check("par_released", 8'h00, dev_data_oe);
    @(posedge clk);
    far_ack_n <= 1'b0;
    sawb = 1'b0;
    for (int n = 0; n < 20 && txd0 !== 1'b0; n++) begin
      @(posedge clk);
      if (dev_busy === 1'b1) sawb = 1'b1;
    end
    check("busy_first", 8'h01, {7'h00, sawb});
    check("busy_released", 8'h00, {7'h00, dev_busy});
    check("in_ack", 8'h00, {7'h00, txd0});
    far_data <= 8'hC3;
    far_ack_n <= 1'b1;
    op({1'b1, KIND_RX}, 7'h00, 8'h00); check("vec_rx", VEC_RX, rdv);
    op(RD, ADDR_RX_DATA, 8'h00); check("rx_latch", 8'h3C, rdv);
    cts_n <= 4'b0101;
    far_data <= 8'h99;
    op(RD, ADDR_RX_DATA, 8'h00); check("rx_buffer", 8'h99, rdv);
    check("req_modem", 8'h01, {7'h00, stat[2 + SVC_MDM]});
    op({1'b1, KIND_MDM}, 7'h00, 8'h00); check("vec_modem", VEC_MDM, rdv);
    check("modem_clear", 8'h00, {7'h00, stat[2 + SVC_MDM]});
    report_and_stop;
  end

  // The whole sequence needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end
endmodule
